// ==== usbf_pkg.sv ====
`default_nettype none
package usbf_pkg;
	// Clock
	localparam int unsigned CLK_PERIOD_NS = 50;
	// Line timing
	localparam int unsigned BUS_RST_NS = 2500;
	localparam int unsigned BUS_RST_CYC = (BUS_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SUSPEND_US = 3000;
	localparam int unsigned SUSPEND_CYC = (SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FRAME_US = 1000;
	localparam int unsigned FRAME_CYC = (FRAME_US * 1000) / CLK_PERIOD_NS;
	// Register byte offsets
	localparam logic [7:0] OFS_ISO_CTRL = 8'h00;
	localparam logic [7:0] OFS_IRQ_CTRL = 8'h04;
	localparam logic [7:0] OFS_FUNC_IE = 8'h1C;
	localparam logic [7:0] OFS_FUNC_IS = 8'h20;
	localparam logic [7:0] OFS_CTRL_EP_CTRL_STATUS_REG = 8'h24;
	localparam logic [7:0] OFS_EP0_FIFO = 8'h28;
	localparam logic [7:0] OFS_EP0_CFG = 8'h2C;
	localparam logic [7:0] OFS_EP_CFG = 8'h30;
	// Field positions
	localparam int unsigned ISO_ART_SOF_BIT = 2;
	localparam int unsigned IRQ_REQ_BIT = 3;
	localparam int unsigned CSR_OUT_RDY = 0;
	localparam int unsigned CSR_IN_RDY = 1;
	localparam int unsigned CSR_SETUP = 2;
	localparam int unsigned CSR_DATA_END = 3;
	localparam int unsigned CSR_SETUP_END = 4;
	localparam int unsigned CSR_CONT = 5;
	localparam int unsigned CSR_DE_IRQ_EN = 6;
	localparam int unsigned CSR_SET_IN_RDY = 8;
	localparam int unsigned CSR_OUT_RELEASE = 9;
	localparam int unsigned CSR_CLR_SETUP = 10;
	localparam int unsigned CSR_CLR_SETUP_END = 11;
	localparam int unsigned CSR_SET_DATA_END = 12;
	localparam int unsigned FIS_FLOW_LSB = 8;
	localparam int unsigned FIS_IN_EN_LSB = 17;
	localparam int unsigned FIS_FINAL_ACK = 21;
	localparam int unsigned FIS_W = 22;
	// Sizes and reset values
	localparam int unsigned EP0_BUF_BYTES = 128;
	localparam logic [6:0] EP0_MAXP_RST = 7'h08;
	localparam logic [4:0] EP_UNITS_MAX = 5'h10;
	localparam int unsigned EP_UNIT_SHIFT = 6;
	// Interrupt line indices
	typedef enum logic [2:0] {IRQ_EP0, IRQ_FUNC, IRQ_BUS_RST, IRQ_RESUME, IRQ_SUSPEND, IRQ_SOF}
		usbf_irq_t;
	localparam int unsigned NUM_IRQ = 6;
endpackage : usbf_pkg
`default_nettype wire

// ==== usbf_evt_fifo.sv ====
// Functional notes
// - Long SE0 raises bus reset, resets registers
// - Non-idle line in suspend raises resume
// - Idle J-state for 3ms raises suspend
// - Received frame start raises frame interrupt
// - Artificial frame timer when iso bit 2 set
// - Each interrupt gated by its control register
// - Control endpoint data set done interrupts
// - Data-end clear is control cause when its enable bit is set
// - Premature control end sets abort flag, interrupts
// - Endpoint completion or flow error: function interrupt
// - IN enable or bad final ACK: function interrupt
// - Per-source function enable and status bits
// - Control endpoint fixed 128-byte IN buffer
// - Endpoint buffer up to 1K, doubled optionally
// - IN write pointer advances 2 word, 1 byte
// - Byte or 16-bit CPU accesses accepted
// - IN-ready strobe sets full, send clears it
// - Continuous mode splits set into max packets
// - SETUP sets OUT-full, setup, interrupts
// - Good OUT sets OUT-full, release clears it
`timescale 1ns/100ps
`default_nettype none
module usbf_evt_fifo #(
	parameter int unsigned SUSPEND_CYC = usbf_pkg::SUSPEND_CYC,
	parameter int unsigned FRAME_CYC = usbf_pkg::FRAME_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Line state
	input wire logic line_se0,
	input wire logic line_j_idle,
	// Protocol engine event pulses
	input wire logic sof_rx,
	input wire logic setup_rx,
	input wire logic out_pkt_good,
	input wire logic in_pkt_acked,
	input wire logic setup_end_evt,
	input wire logic data_end_done,
	input wire logic [7:0] ep_data_done,
	input wire logic [8:0] flow_err,
	input wire logic [3:0] in_ep_enabled,
	input wire logic final_ack_bad,
	// Control endpoint IN transmit side
	input wire logic [6:0] tx_rd_addr,
	output logic [7:0] tx_rd_data,
	output logic tx_pkt_valid,
	output logic [6:0] tx_pkt_start,
	output logic [7:0] tx_pkt_len,
	// Interrupts and line status
	output logic [5:0] irq,
	output logic usb_reset_pulse,
	output logic suspended
);
	////////////////////////////////////////////////////////////////////////////////////
	logic [7:0] ep0_mem [usbf_pkg::EP0_BUF_BYTES];
	logic [31:0] se0_cnt_ff, nxt_se0_cnt, idle_cnt_ff, nxt_idle_cnt, frm_cnt_ff, nxt_frm_cnt;
	logic bus_rst_ff, nxt_bus_rst, susp_ff, nxt_susp;
	logic art_sof_ff, nxt_art_sof;
	logic [3:0] irqc_ff [usbf_pkg::NUM_IRQ];
	logic [3:0] nxt_irqc [usbf_pkg::NUM_IRQ];
	logic [usbf_pkg::FIS_W-1:0] fie_ff, nxt_fie, fis_ff, nxt_fis, f_evt;
	logic out_rdy_ff, nxt_out_rdy, in_rdy_ff, nxt_in_rdy, setup_ff, nxt_setup;
	logic de_ff, nxt_de, se_ff, nxt_se, cont_ff, nxt_cont, de_ie_ff, nxt_de_ie;
	logic [6:0] maxp_ff, nxt_maxp;
	logic [7:0] wptr_ff, nxt_wptr, toff_ff, nxt_toff, pkt_len;
	logic [11:0] epc_ff [4];
	logic [11:0] nxt_epc [4];
	logic [31:0] rd_val, prdata_ff, wm;
	logic [7:0] tx_data_ff;
	logic hit, wr, wr_b1, mem_we0, mem_we1, in_done;
	logic [usbf_pkg::NUM_IRQ-1:0] ev, ev_line;
	logic ev_ep0, ev_func;

	////////////////////////////////////////////////////////////////////////////////////
	// APB decode, byte-lane mask, registered read data
	assign wr = psel && penable && pwrite && hit;
	assign wr_b1 = wr && pstrb[1];
	assign wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_ff;

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
		usbf_pkg::OFS_ISO_CTRL: rd_val[usbf_pkg::ISO_ART_SOF_BIT] = art_sof_ff;
		usbf_pkg::OFS_FUNC_IE: rd_val[usbf_pkg::FIS_W-1:0] = fie_ff;
		usbf_pkg::OFS_FUNC_IS: rd_val[usbf_pkg::FIS_W-1:0] = fis_ff;
		usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG: rd_val[6:0] = {de_ie_ff, cont_ff, se_ff, de_ff, setup_ff,
			in_rdy_ff, out_rdy_ff};
		usbf_pkg::OFS_EP0_FIFO: rd_val = 32'h0000_0000;
		usbf_pkg::OFS_EP0_CFG: rd_val = {8'h00, wptr_ff, 9'h000, maxp_ff};
		default: begin
			hit = 1'b0;
			for (int i = 0; i < usbf_pkg::NUM_IRQ; i++) begin
				if (paddr == usbf_pkg::OFS_IRQ_CTRL + 8'(4 * i)) begin
					hit = 1'b1;
					rd_val[3:0] = irqc_ff[i];
				end
			end
			for (int i = 0; i < 4; i++) begin
				if (paddr == usbf_pkg::OFS_EP_CFG + 8'(4 * i)) begin
					hit = 1'b1;
					rd_val[11:0] = epc_ff[i];
					rd_val[27:16] = {1'b0, epc_ff[i][4:0], 6'h00} << epc_ff[i][5];
				end
			end
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Line watch: bus reset, suspend, resume, frame timer
	always_comb begin
		nxt_se0_cnt = line_se0 ? se0_cnt_ff : 32'h0000_0000;
		nxt_bus_rst = 1'b0;
		if (line_se0 && se0_cnt_ff < 32'(usbf_pkg::BUS_RST_CYC)) begin
			nxt_se0_cnt = se0_cnt_ff + 32'h0000_0001;
			nxt_bus_rst = (se0_cnt_ff == 32'(usbf_pkg::BUS_RST_CYC - 1));
		end
		nxt_susp = susp_ff;
		nxt_idle_cnt = 32'h0000_0000;
		ev_line = '0;
		if (susp_ff) begin
			if (!line_j_idle) begin
				nxt_susp = 1'b0;
				ev_line[usbf_pkg::IRQ_RESUME] = 1'b1;
			end
		end else if (line_j_idle) begin
			nxt_idle_cnt = idle_cnt_ff + 32'h0000_0001;
			if (idle_cnt_ff == 32'(SUSPEND_CYC - 1)) begin
				nxt_susp = 1'b1;
				ev_line[usbf_pkg::IRQ_SUSPEND] = 1'b1;
				nxt_idle_cnt = 32'h0000_0000;
			end
		end
		nxt_frm_cnt = frm_cnt_ff;
		if (sof_rx) begin
			nxt_frm_cnt = 32'h0000_0000;
			ev_line[usbf_pkg::IRQ_SOF] = 1'b1;
		end else if (art_sof_ff && !susp_ff) begin
			nxt_frm_cnt = frm_cnt_ff + 32'h0000_0001;
			if (frm_cnt_ff == 32'(FRAME_CYC - 1)) begin
				nxt_frm_cnt = 32'h0000_0000;
				ev_line[usbf_pkg::IRQ_SOF] = 1'b1;
			end
		end
		ev_line[usbf_pkg::IRQ_BUS_RST] = bus_rst_ff;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			se0_cnt_ff <= 32'h0000_0000;
			idle_cnt_ff <= 32'h0000_0000;
			frm_cnt_ff <= 32'h0000_0000;
			bus_rst_ff <= 1'b0;
			susp_ff <= 1'b0;
		end else begin
			se0_cnt_ff <= nxt_se0_cnt;
			idle_cnt_ff <= nxt_idle_cnt;
			frm_cnt_ff <= nxt_frm_cnt;
			bus_rst_ff <= nxt_bus_rst;
			susp_ff <= nxt_susp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Control endpoint flags, IN buffer, packet split
	always_comb begin
		pkt_len = wptr_ff - toff_ff;
		if (cont_ff && pkt_len > {1'b0, maxp_ff})
			pkt_len = {1'b0, maxp_ff};
	end

	assign in_done = in_pkt_acked && in_rdy_ff && (!cont_ff || toff_ff + pkt_len >= wptr_ff);

	always_comb begin
		nxt_out_rdy = (out_rdy_ff && !(wr_b1 && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG
			&& pwdata[usbf_pkg::CSR_OUT_RELEASE])) || out_pkt_good || setup_rx;
		nxt_setup = (setup_ff && !(wr_b1 && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG
			&& pwdata[usbf_pkg::CSR_CLR_SETUP])) || setup_rx;
		nxt_se = (se_ff && !(wr_b1 && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG
			&& pwdata[usbf_pkg::CSR_CLR_SETUP_END])) || setup_end_evt;
		nxt_de = (de_ff || (wr_b1 && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG
			&& pwdata[usbf_pkg::CSR_SET_DATA_END])) && !data_end_done;
		nxt_cont = cont_ff;
		nxt_de_ie = de_ie_ff;
		if (wr && pstrb[0] && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG) begin
			nxt_cont = pwdata[usbf_pkg::CSR_CONT];
			nxt_de_ie = pwdata[usbf_pkg::CSR_DE_IRQ_EN];
		end
		nxt_maxp = maxp_ff;
		if (wr && pstrb[0] && paddr == usbf_pkg::OFS_EP0_CFG)
			nxt_maxp = pwdata[6:0];
		nxt_in_rdy = in_rdy_ff;
		nxt_wptr = wptr_ff;
		nxt_toff = toff_ff;
		mem_we0 = 1'b0;
		mem_we1 = 1'b0;
		if (wr && paddr == usbf_pkg::OFS_EP0_FIFO && !in_rdy_ff && pstrb[0]) begin
			if (pstrb[1] && wptr_ff <= 8'(usbf_pkg::EP0_BUF_BYTES - 2)) begin
				mem_we0 = 1'b1;
				mem_we1 = 1'b1;
				nxt_wptr = wptr_ff + 8'h02;
			end else if (!pstrb[1] && wptr_ff < 8'(usbf_pkg::EP0_BUF_BYTES)) begin
				mem_we0 = 1'b1;
				nxt_wptr = wptr_ff + 8'h01;
			end
		end
		if (in_rdy_ff && in_pkt_acked) begin
			nxt_toff = toff_ff + pkt_len;
			if (in_done) begin
				nxt_in_rdy = 1'b0;
				nxt_wptr = 8'h00;
				nxt_toff = 8'h00;
			end
		end
		if (wr_b1 && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG && pwdata[usbf_pkg::CSR_SET_IN_RDY])
			nxt_in_rdy = 1'b1;
		ev_ep0 = out_pkt_good || setup_rx || in_done || setup_end_evt
			|| (de_ff && data_end_done && de_ie_ff);
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Function sources, interrupt control, endpoint buffer setup
	assign f_evt = {final_ack_bad, in_ep_enabled, flow_err, ep_data_done};
	assign ev_func = |(f_evt & fie_ff);
	assign ev = ev_line | {4'h0, ev_func, ev_ep0};

	always_comb begin
		nxt_fis = fis_ff;
		if (wr && paddr == usbf_pkg::OFS_FUNC_IS)
			nxt_fis = fis_ff & ~(pwdata[usbf_pkg::FIS_W-1:0] & wm[usbf_pkg::FIS_W-1:0]);
		nxt_fis = nxt_fis | f_evt;
		nxt_fie = fie_ff;
		if (wr && paddr == usbf_pkg::OFS_FUNC_IE)
			nxt_fie = (fie_ff & ~wm[usbf_pkg::FIS_W-1:0]) | (pwdata[usbf_pkg::FIS_W-1:0]
				& wm[usbf_pkg::FIS_W-1:0]);
		nxt_art_sof = art_sof_ff;
		if (wr && pstrb[0] && paddr == usbf_pkg::OFS_ISO_CTRL)
			nxt_art_sof = pwdata[usbf_pkg::ISO_ART_SOF_BIT];
		for (int i = 0; i < usbf_pkg::NUM_IRQ; i++) begin
			nxt_irqc[i] = irqc_ff[i];
			if (wr && pstrb[0] && paddr == usbf_pkg::OFS_IRQ_CTRL + 8'(4 * i))
				nxt_irqc[i] = {irqc_ff[i][usbf_pkg::IRQ_REQ_BIT] & pwdata[3], pwdata[2:0]};
			if (ev[i])
				nxt_irqc[i][usbf_pkg::IRQ_REQ_BIT] = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			nxt_epc[i] = epc_ff[i];
			if (wr && paddr == usbf_pkg::OFS_EP_CFG + 8'(4 * i)) begin
				if (pstrb[0]) begin
					nxt_epc[i][5:0] = pwdata[5:0];
					if (pwdata[4:0] > usbf_pkg::EP_UNITS_MAX)
						nxt_epc[i][4:0] = usbf_pkg::EP_UNITS_MAX;
				end
				if (pstrb[1])
					nxt_epc[i][11:6] = pwdata[11:6];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < usbf_pkg::NUM_IRQ; i++)
				irqc_ff[i] <= 4'h0;
		end else begin
			for (int i = 0; i < usbf_pkg::NUM_IRQ; i++)
				irqc_ff[i] <= nxt_irqc[i];
		end
	end

	// Bus reset returns the block's own registers, except the interrupt controls, to defaults
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			art_sof_ff <= 1'b0;
			fie_ff <= '0;
			fis_ff <= '0;
			out_rdy_ff <= 1'b0;
			in_rdy_ff <= 1'b0;
			setup_ff <= 1'b0;
			de_ff <= 1'b0;
			se_ff <= 1'b0;
			cont_ff <= 1'b0;
			de_ie_ff <= 1'b0;
			maxp_ff <= usbf_pkg::EP0_MAXP_RST;
			wptr_ff <= 8'h00;
			toff_ff <= 8'h00;
			for (int i = 0; i < 4; i++)
				epc_ff[i] <= 12'h000;
		end else if (bus_rst_ff) begin
			art_sof_ff <= 1'b0;
			fie_ff <= '0;
			fis_ff <= '0;
			out_rdy_ff <= 1'b0;
			in_rdy_ff <= 1'b0;
			setup_ff <= 1'b0;
			de_ff <= 1'b0;
			se_ff <= 1'b0;
			cont_ff <= 1'b0;
			de_ie_ff <= 1'b0;
			maxp_ff <= usbf_pkg::EP0_MAXP_RST;
			wptr_ff <= 8'h00;
			toff_ff <= 8'h00;
			for (int i = 0; i < 4; i++)
				epc_ff[i] <= 12'h000;
		end else begin
			art_sof_ff <= nxt_art_sof;
			fie_ff <= nxt_fie;
			fis_ff <= nxt_fis;
			out_rdy_ff <= nxt_out_rdy;
			in_rdy_ff <= nxt_in_rdy;
			setup_ff <= nxt_setup;
			de_ff <= nxt_de;
			se_ff <= nxt_se;
			cont_ff <= nxt_cont;
			de_ie_ff <= nxt_de_ie;
			maxp_ff <= nxt_maxp;
			wptr_ff <= nxt_wptr;
			toff_ff <= nxt_toff;
			for (int i = 0; i < 4; i++)
				epc_ff[i] <= nxt_epc[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// IN buffer storage and read data registers
	always_ff @(posedge sys_clk) begin
		if (mem_we0)
			ep0_mem[wptr_ff[6:0]] <= pwdata[7:0];
		if (mem_we1)
			ep0_mem[wptr_ff[6:0] + 7'h01] <= pwdata[15:8];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
			tx_data_ff <= 8'h00;
		end else begin
			if (psel && !penable)
				prdata_ff <= rd_val;
			tx_data_ff <= ep0_mem[tx_rd_addr];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		for (int i = 0; i < usbf_pkg::NUM_IRQ; i++)
			irq[i] = irqc_ff[i][usbf_pkg::IRQ_REQ_BIT] && (irqc_ff[i][2:0] != 3'h0);
	end

	assign tx_rd_data = tx_data_ff;
	assign tx_pkt_valid = in_rdy_ff;
	assign tx_pkt_start = toff_ff[6:0];
	assign tx_pkt_len = pkt_len;
	assign usb_reset_pulse = bus_rst_ff;
	assign suspended = susp_ff;
endmodule : usbf_evt_fifo
`default_nettype wire

// ==== usbf_evt_fifo_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module usbf_chk #(
	parameter int unsigned SUSPEND_CYC = 20
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Line and transmit
	input wire logic line_se0,
	input wire logic line_j_idle,
	input wire logic in_pkt_acked,
	input wire logic tx_pkt_valid,
	input wire logic usb_reset_pulse,
	input wire logic suspended
);
	logic [6:0] se0_cnt_ff;
	logic [6:0] nxt_se0_cnt;
	logic [15:0] idle_cnt_ff;
	logic [15:0] nxt_idle_cnt;
	// Saturating run lengths of SE0 and idle J
	always_comb begin
		nxt_se0_cnt = line_se0 ? se0_cnt_ff + {6'h00, ~&se0_cnt_ff} : 7'h00;
		nxt_idle_cnt = line_j_idle ? idle_cnt_ff + {15'h0000, ~&idle_cnt_ff} : 16'h0000;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			se0_cnt_ff <= 7'h00;
			idle_cnt_ff <= 16'h0000;
		end else begin
			se0_cnt_ff <= nxt_se0_cnt;
			idle_cnt_ff <= nxt_idle_cnt;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	pready_high_a: assert property (pready)
		else $error("pready low");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	rdata_hold_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
		else $error("prdata changed outside setup");
	rst_pulse_one_a: assert property (usb_reset_pulse |=> !usb_reset_pulse)
		else $error("bus reset pulse too long");
	rst_after_se0_a: assert property (usb_reset_pulse |-> se0_cnt_ff >= 7'h31)
		else $error("bus reset on short SE0");
	rst_on_se0_a: assert property (se0_cnt_ff == 7'h32 |-> ##[0:2] usb_reset_pulse)
		else $error("long SE0 without bus reset");
	suspend_idle_a: assert property ($rose(suspended) |-> idle_cnt_ff >= 16'(SUSPEND_CYC - 1))
		else $error("suspend too early");
	resume_wakes_a: assert property (suspended && !line_j_idle |-> ##[1:2] !suspended)
		else $error("no resume on activity");
	in_full_set_a: assert property ($rose(tx_pkt_valid)
		|-> $past(psel && penable && pwrite && paddr == usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG))
		else $error("IN full without strobe");
	in_full_clear_a: assert property ($fell(tx_pkt_valid) |-> $past(in_pkt_acked)
		|| $past(usb_reset_pulse) || $past(usb_reset_pulse, 2))
		else $error("IN full cleared without ack");
endmodule : usbf_chk
`default_nettype wire

// ==== usbf_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module usbf_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Line and event pulses
	output logic line_se0,
	output logic line_j_idle,
	output logic [4:0] evt,
	output logic [21:0] fsrc,
	// Control IN transmit
	output logic in_pkt_acked,
	output logic [6:0] tx_rd_addr,
	input wire logic [7:0] tx_rd_data,
	input wire logic tx_pkt_valid,
	input wire logic [6:0] tx_pkt_start,
	input wire logic [7:0] tx_pkt_len
);
	logic [7:0] rx_q[$];
	logic [7:0] len_q[$];
	int slow = 0;
	initial begin
		line_se0 = 1'b0;
		line_j_idle = 1'b0;
		evt = 5'h00;
		fsrc = 22'h000000;
	end
	task automatic set_line(input logic se0, input logic j_idle);
		@(posedge sys_clk);
		line_se0 <= se0;
		line_j_idle <= j_idle;
	endtask : set_line
	task automatic pulse(input logic [4:0] e, input logic [21:0] f);
		@(posedge sys_clk);
		evt <= e;
		fsrc <= f;
		@(posedge sys_clk);
		evt <= 5'h00;
		fsrc <= 22'h000000;
	endtask : pulse
	// Fetches each offered packet byte by byte, then acknowledges it
	initial begin : tx_side
		logic [7:0] len;
		logic [6:0] start;
		in_pkt_acked = 1'b0;
		tx_rd_addr = 7'h00;
		forever begin
			@(negedge sys_clk);
			if (tx_pkt_valid === 1'b1 && rst === 1'b0) begin
				len = tx_pkt_len;
				start = tx_pkt_start;
				len_q.push_back(len);
				repeat (slow) @(posedge sys_clk);
				for (int i = 0; i < len; i++) begin
					@(posedge sys_clk);
					tx_rd_addr <= start + 7'(i);
					@(posedge sys_clk);
					@(negedge sys_clk);
					rx_q.push_back(tx_rd_data);
				end
				@(posedge sys_clk);
				in_pkt_acked <= 1'b1;
				@(posedge sys_clk);
				in_pkt_acked <= 1'b0;
				tx_rd_addr <= ~tx_rd_addr;
			end
		end
	end
endmodule : usbf_host_model
`default_nettype wire

// ==== usbf_evt_fifo_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module usbf_evt_fifo_tb;
	localparam int unsigned SUSP = 20;
	localparam int unsigned FRM = 30;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, line_se0, line_j_idle, in_pkt_acked, tx_pkt_valid;
	logic usb_reset_pulse, suspended;
	logic [4:0] evt;
	logic [21:0] fsrc;
	logic [6:0] tx_rd_addr, tx_pkt_start;
	logic [7:0] tx_rd_data, tx_pkt_len;
	logic [5:0] irq;
	logic [6:0] wv;
	int num_errors = 0;
	int compares = 0;
	int n;
	assign wv = {~tx_pkt_valid, irq};
	always #25 sys_clk = ~sys_clk;
	usbf_evt_fifo #(.SUSPEND_CYC(SUSP), .FRAME_CYC(FRM)) usbf_evt_fifo_i (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_se0(line_se0), .line_j_idle(line_j_idle), .sof_rx(evt[0]),
		.setup_rx(evt[1]), .out_pkt_good(evt[2]), .in_pkt_acked(in_pkt_acked),
		.setup_end_evt(evt[3]), .data_end_done(evt[4]), .ep_data_done(fsrc[7:0]),
		.flow_err(fsrc[16:8]), .in_ep_enabled(fsrc[20:17]), .final_ack_bad(fsrc[21]),
		.tx_rd_addr(tx_rd_addr), .tx_rd_data(tx_rd_data), .tx_pkt_valid(tx_pkt_valid),
		.tx_pkt_start(tx_pkt_start), .tx_pkt_len(tx_pkt_len), .irq(irq),
		.usb_reset_pulse(usb_reset_pulse), .suspended(suspended));
	usbf_host_model host_i (.sys_clk(sys_clk), .rst(rst), .line_se0(line_se0),
		.line_j_idle(line_j_idle), .evt(evt), .fsrc(fsrc), .in_pkt_acked(in_pkt_acked),
		.tx_rd_addr(tx_rd_addr), .tx_rd_data(tx_rd_data), .tx_pkt_valid(tx_pkt_valid),
		.tx_pkt_start(tx_pkt_start), .tx_pkt_len(tx_pkt_len));
	task automatic final_report;
		if (num_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : cmp
	task automatic cmp_bit(input logic g, input logic x);
		cmp({31'h00000000, g}, {31'h00000000, x});
	endtask : cmp_bit
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h00000000, 4'h0);
	endtask : rd
	task automatic clr(input int i);
		wr(usbf_pkg::OFS_IRQ_CTRL + 8'(4 * i), 32'h00000001, 4'h1);
	endtask : clr
	task automatic wait_bit(input int i, input int lim);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				num_errors++;
				final_report();
			end
		end while (wv[i] !== 1'b1);
	endtask : wait_bit
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(usbf_pkg::OFS_EP0_CFG);
		cmp(r, 32'h00000008);
		rd(8'hFC);
		cmp({r[30:0], e}, 32'h00000001);
		for (int i = 0; i < 6; i++) clr(i);
		host_i.pulse(5'h02, 22'h000000);
		wait_bit(0, 1);
		rd(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG);
		cmp(r, 32'h00000005);
		clr(0);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00001000, 4'h2);
		host_i.pulse(5'h10, 22'h000000);
		rd(usbf_pkg::OFS_IRQ_CTRL);
		cmp(r, 32'h00000001);
		wr(usbf_pkg::OFS_IRQ_CTRL, 32'h00000000, 4'h1);
		host_i.pulse(5'h04, 22'h000000);
		@(negedge sys_clk);
		cmp_bit(irq[0], 1'b0);
		rd(usbf_pkg::OFS_IRQ_CTRL);
		cmp(r, 32'h00000008);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000600, 4'h2);
		rd(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG);
		cmp(r, 32'h00000000);
		clr(0);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00001040, 4'h3);
		host_i.pulse(5'h10, 22'h000000);
		wait_bit(0, 1);
		clr(0);
		host_i.pulse(5'h08, 22'h000000);
		wait_bit(0, 1);
		rd(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG);
		cmp(r, 32'h00000050);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000800, 4'h3);
		clr(0);
		host_i.pulse(5'h01, 22'h000000);
		wait_bit(5, 1);
		clr(5);
		wr(usbf_pkg::OFS_FUNC_IE, 32'h003FFFFF, 4'hF);
		for (int i = 0; i < 22; i++) begin
			host_i.pulse(5'h00, 22'h000001 << i);
			rd(usbf_pkg::OFS_FUNC_IS);
			cmp(r, 32'h00000001 << i);
			wr(usbf_pkg::OFS_FUNC_IS, 32'h00000001 << i, 4'hF);
		end
		wait_bit(1, 1);
		clr(1);
		wr(usbf_pkg::OFS_FUNC_IE, 32'h00000000, 4'hF);
		host_i.pulse(5'h00, 22'h000001);
		rd(usbf_pkg::OFS_FUNC_IS);
		cmp(r, 32'h00000001);
		@(negedge sys_clk);
		cmp_bit(irq[1], 1'b0);
		wr(usbf_pkg::OFS_FUNC_IS, 32'h00000001, 4'hF);
		wr(usbf_pkg::OFS_ISO_CTRL, 32'h00000004, 4'h1);
		wait_bit(5, FRM + 10);
		cmp_bit(n >= FRM - 3 && n <= FRM + 3, 1'b1);
		wr(usbf_pkg::OFS_ISO_CTRL, 32'h00000000, 4'h1);
		clr(5);
		host_i.set_line(1'b0, 1'b1);
		wait_bit(4, SUSP + 10);
		cmp_bit(n >= SUSP - 1 && n <= SUSP + 4 && suspended, 1'b1);
		clr(4);
		host_i.set_line(1'b0, 1'b0);
		wait_bit(3, 4);
		cmp_bit(suspended, 1'b0);
		clr(3);
		wr(usbf_pkg::OFS_EP0_FIFO, 32'h0000B2A1, 4'h3);
		wr(usbf_pkg::OFS_EP0_FIFO, 32'h000000C3, 4'h1);
		rd(usbf_pkg::OFS_EP0_CFG);
		cmp(r, 32'h00030008);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000100, 4'h2);
		wait_bit(6, 100);
		cmp({8'h00, host_i.rx_q[2], host_i.rx_q[1], host_i.rx_q[0]}, 32'h00C3B2A1);
		wait_bit(0, 1);
		clr(0);
		rd(usbf_pkg::OFS_EP0_CFG);
		cmp(r, 32'h00000008);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000100, 4'h2);
		wait_bit(6, 100);
		cmp(32'(host_i.len_q[1]), 32'h00000000);
		host_i.slow = 3;
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000020, 4'h1);
		for (int i = 0; i < 6; i++) wr(usbf_pkg::OFS_EP0_FIFO, {16'h0000, 8'(2 * i + 1), 8'(2 * i)}, 4'h3);
		wr(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG, 32'h00000120, 4'h3);
		wr(usbf_pkg::OFS_EP0_FIFO, 32'h0000FFFF, 4'h3);
		rd(usbf_pkg::OFS_EP0_CFG);
		cmp(r, 32'h000C0008);
		wait_bit(6, 300);
		cmp({16'h0004, host_i.len_q[2], host_i.len_q[3]}, {16'(host_i.len_q.size()), 16'h0804});
		for (int i = 0; i < 12; i++) cmp(32'(host_i.rx_q[i + 3]), 32'(i));
		clr(0);
		wr(usbf_pkg::OFS_EP_CFG, 32'h00000022, 4'h3);
		rd(usbf_pkg::OFS_EP_CFG);
		cmp(r, 32'h01000022);
		wr(usbf_pkg::OFS_EP_CFG + 8'h04, 32'h0000001F, 4'h3);
		rd(usbf_pkg::OFS_EP_CFG + 8'h04);
		cmp({20'h00000, r[27:16]}, 32'h00000400);
		host_i.set_line(1'b1, 1'b0);
		wait_bit(2, 80);
		cmp_bit(n >= 50 && n <= 56, 1'b1);
		host_i.set_line(1'b0, 1'b0);
		rd(usbf_pkg::OFS_EP_CFG);
		cmp(r, 32'h00000000);
		rd(usbf_pkg::OFS_CTRL_EP_CTRL_STATUS_REG);
		cmp(r, 32'h00000000);
		rd(usbf_pkg::OFS_IRQ_CTRL + 8'h08);
		cmp(r, 32'h00000009);
		clr(2);
		final_report();
	end
endmodule : usbf_evt_fifo_tb
bind usbf_evt_fifo usbf_chk #(.SUSPEND_CYC(SUSPEND_CYC)) chk_i (.sys_clk(sys_clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .line_se0(line_se0), .line_j_idle(line_j_idle),
	.in_pkt_acked(in_pkt_acked), .tx_pkt_valid(tx_pkt_valid),
	.usb_reset_pulse(usb_reset_pulse), .suspended(suspended));
`default_nettype wire
